/* bcf_pkg.sv */
// Package: register map, field positions and bus carriers for break flags
package bcf_pkg;

  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h004;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h008;

  localparam int BIT_LBUS_A = 15;
  localparam int BIT_LBUS_B = 14;
  localparam int BIT_IBUS_A = 13;
  localparam int BIT_IBUS_B = 12;
  localparam int BIT_FLAG_LO = 12;
  localparam int BIT_PC_TRACE = 11;
  localparam int BIT_FETCH_TIMING = 10;
  localparam int BIT_DATA_CMP = 7;
  localparam int NUM_FLAGS = 4;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // Condition hits reported by the comparators watching the core buses, plus the instruction retire indication
  typedef struct packed {
    logic a_lbus;
    logic b_lbus;
    logic a_ibus;
    logic b_ibus;
    logic b_lbus_data;
    logic b_ibus_data;
    logic a_fetch;
    logic insn_retire;
  } bcf_watch_t;

  // Break requests toward the core
  typedef struct packed {
    logic a_before;
    logic a_after;
    logic b_break;
  } bcf_break_t;

endpackage : bcf_pkg

/* bcf_chan_qual.sv */
// Channel B hit qualifier with optional data bus comparison
`timescale 1ns/1ps
module bcf_chan_qual (
  // Condition inputs
  input wire logic addr_hit,
  input wire logic data_hit,
  input wire logic data_compare_enable_b,
  // Qualified hit
  output logic hit
);

  // Data bus joins the condition only when enabled
  assign hit = addr_hit & (~data_compare_enable_b | data_hit);

endmodule : bcf_chan_qual

/* bcf_fetch_timing.sv */
// Channel A fetch break timing: before or after execution
`timescale 1ns/1ps
module bcf_fetch_timing (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Inputs
  input wire logic fetch_hit,
  input wire logic insn_retire,
  input wire logic fetch_break_timing_a,
  // Break pulses
  output logic brk_before,
  output logic brk_after
);

  logic pending_reg;

  // Hold an after-execution break until the instruction retires
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pending_reg <= 1'b0;
    end
    else if (fetch_hit && fetch_break_timing_a)
    begin
      pending_reg <= 1'b1;
    end
    else if (insn_retire)
    begin
      pending_reg <= 1'b0;
    end
  end

  // One-cycle break pulses
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      brk_before <= 1'b0;
      brk_after <= 1'b0;
    end
    else
    begin
      brk_before <= fetch_hit & ~fetch_break_timing_a;
      brk_after <= pending_reg & insn_retire;
    end
  end

endmodule : bcf_fetch_timing

/* bcf_break_ctrl.sv */
// Break control flags register with APB slave and interrupt
`timescale 1ns/1ps
// Functional notes
// - Bits 31..16 and 9..8 of break control always read zero.
// - Channel A L bus match sets bit 15 until software clears it.
// - Channel B L bus match sets bit 14 until software clears it.
// - Channel A I bus match sets bit 13 until software clears it.
// - Channel B I bus match sets bit 12 until software clears it.
// - Writing zero to a match flag clears it; writing one leaves it.
// - Trace enable bit drives PC branch tracing; resets to zero.
// - Bit 10 picks channel A fetch break before or after execution.
// - Bit 7 adds data bus comparison to the channel B condition.
module bcf_break_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Monitored core buses
  input wire bcf_pkg::bcf_watch_t watch,
  // Break and trace controls
  output bcf_pkg::bcf_break_t brk,
  output logic pc_trace_enable,
  output logic data_compare_enable_b,
  output logic fetch_break_timing_a,
  // Interrupt
  output logic irq
);

  logic [3:0] flag_q;
  logic [3:0] evt;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic pc_trace_reg;
  logic timing_a_reg;
  logic data_cmp_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_next;
  logic hit_b_lbus;
  logic hit_b_ibus;
  logic setup;
  logic access;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic mapped;
  logic a_before_pulse;
  logic a_after_pulse;
  logic b_break_reg;

  // APB phase decode
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign mapped = (paddr == bcf_pkg::OFS_CTRL) ||
                  (paddr == bcf_pkg::OFS_IRQ_STAT) ||
                  (paddr == bcf_pkg::OFS_IRQ_MASK);
  assign wr_ctrl = access & pwrite & (paddr == bcf_pkg::OFS_CTRL);
  assign wr_stat = access & pwrite & (paddr == bcf_pkg::OFS_IRQ_STAT);
  assign wr_mask = access & pwrite & (paddr == bcf_pkg::OFS_IRQ_MASK);
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = prdata_reg;

  // Channel B qualification on each bus
  bcf_chan_qual u_qual_lbus (
    .addr_hit(watch.b_lbus),
    .data_hit(watch.b_lbus_data),
    .data_compare_enable_b(data_cmp_reg),
    .hit(hit_b_lbus)
  );

  bcf_chan_qual u_qual_ibus (
    .addr_hit(watch.b_ibus),
    .data_hit(watch.b_ibus_data),
    .data_compare_enable_b(data_cmp_reg),
    .hit(hit_b_ibus)
  );

  // Events in flag order, bit 12 upward
  assign evt = {watch.a_lbus, hit_b_lbus, watch.a_ibus, hit_b_ibus};

  // Sticky match flags
  generate
    for (genvar i = 0; i < bcf_pkg::NUM_FLAGS; i++)
    begin : g_flag
      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          flag_q[i] <= 1'b0;
        end
        else if (evt[i])
        begin
          flag_q[i] <= 1'b1;
        end
        else if (wr_ctrl && !pwdata[bcf_pkg::BIT_FLAG_LO + i])
        begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Control bits
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pc_trace_reg <= bcf_pkg::CTRL_RESET[bcf_pkg::BIT_PC_TRACE];
      timing_a_reg <= bcf_pkg::CTRL_RESET[bcf_pkg::BIT_FETCH_TIMING];
      data_cmp_reg <= bcf_pkg::CTRL_RESET[bcf_pkg::BIT_DATA_CMP];
    end
    else if (wr_ctrl)
    begin
      pc_trace_reg <= pwdata[bcf_pkg::BIT_PC_TRACE];
      timing_a_reg <= pwdata[bcf_pkg::BIT_FETCH_TIMING];
      data_cmp_reg <= pwdata[bcf_pkg::BIT_DATA_CMP];
    end
  end

  assign pc_trace_enable = pc_trace_reg;
  assign fetch_break_timing_a = timing_a_reg;
  assign data_compare_enable_b = data_cmp_reg;

  // Interrupt status, write one to clear, set wins
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      irq_stat_reg <= bcf_pkg::IRQ_RESET;
    end
    else
    begin
      irq_stat_reg <= evt | (irq_stat_reg & ~({4{wr_stat}} & pwdata[3:0]));
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      irq_mask_reg <= bcf_pkg::IRQ_RESET;
    end
    else if (wr_mask)
    begin
      irq_mask_reg <= pwdata[3:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Read mux; reserved and omitted bits stay zero
  always_comb
  begin
    rd_next = 32'h0000_0000;
    case (paddr)
      bcf_pkg::OFS_CTRL:
      begin
        rd_next[bcf_pkg::BIT_LBUS_A:bcf_pkg::BIT_FLAG_LO] = flag_q;
        rd_next[bcf_pkg::BIT_PC_TRACE] = pc_trace_reg;
        rd_next[bcf_pkg::BIT_FETCH_TIMING] = timing_a_reg;
        rd_next[bcf_pkg::BIT_DATA_CMP] = data_cmp_reg;
      end
      bcf_pkg::OFS_IRQ_STAT:
      begin
        rd_next[3:0] = irq_stat_reg;
      end
      bcf_pkg::OFS_IRQ_MASK:
      begin
        rd_next[3:0] = irq_mask_reg;
      end
      default:
      begin
        rd_next = 32'h0000_0000;
      end
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      prdata_reg <= 32'h0000_0000;
    end
    else if (setup && !pwrite)
    begin
      prdata_reg <= rd_next;
    end
  end

  // Channel A fetch break timing
  bcf_fetch_timing u_fetch (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .fetch_hit(watch.a_fetch),
    .insn_retire(watch.insn_retire),
    .fetch_break_timing_a(timing_a_reg),
    .brk_before(a_before_pulse),
    .brk_after(a_after_pulse)
  );

  // Channel B break request
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      b_break_reg <= 1'b0;
    end
    else
    begin
      b_break_reg <= hit_b_lbus | hit_b_ibus;
    end
  end

  assign brk = {a_before_pulse, a_after_pulse, b_break_reg};

  // Checks
  default clocking cb_sys @(posedge clk_sys);
  endclocking

  default disable iff (!rst_n);

  sequence s_ctrl_read;
    access && !pwrite && paddr == bcf_pkg::OFS_CTRL;
  endsequence

  sequence s_after_armed;
    watch.a_fetch && timing_a_reg;
  endsequence

  a_reserved_zero: assert property (s_ctrl_read |->
    prdata[31:16] == 16'h0000 && prdata[9:8] == 2'h0)
    else $error("reserved bits read nonzero");

  a_lbus_a_set: assert property (watch.a_lbus |=> flag_q[3])
    else $error("lbus A flag not set");

  a_lbus_a_hold: assert property (flag_q[3] &&
    !(wr_ctrl && !pwdata[bcf_pkg::BIT_LBUS_A]) |=> flag_q[3])
    else $error("lbus A flag dropped");

  a_lbus_b_set: assert property (watch.b_lbus && !data_cmp_reg
    |=> flag_q[2])
    else $error("lbus B flag not set");

  a_lbus_b_data: assert property (watch.b_lbus && watch.b_lbus_data
    |=> flag_q[2])
    else $error("qualified lbus B match lost");

  a_ibus_a_set: assert property (watch.a_ibus |=> flag_q[1])
    else $error("ibus A flag not set");

  a_ibus_b_set: assert property (watch.b_ibus && watch.b_ibus_data
    |=> flag_q[0])
    else $error("ibus B flag not set");

  a_flags_hold: assert property (!wr_ctrl |=>
    ($past(flag_q) & ~flag_q) == 4'h0)
    else $error("match flag dropped without write");

  a_flag_clear: assert property (wr_ctrl && pwdata[15:12] == 4'h0 &&
    evt == 4'h0 |=> flag_q == 4'h0)
    else $error("flags not cleared by zero write");

  a_set_wins: assert property (wr_ctrl && watch.a_ibus &&
    !pwdata[bcf_pkg::BIT_IBUS_A] |=> flag_q[1])
    else $error("match lost during clear");

  a_trace_write: assert property (wr_ctrl |=>
    pc_trace_enable == $past(pwdata[bcf_pkg::BIT_PC_TRACE]))
    else $error("trace enable wrong after write");

  a_break_before: assert property (watch.a_fetch && !timing_a_reg
    |=> brk.a_before && !brk.a_after)
    else $error("before break missing");

  a_break_after: assert property (s_after_armed ##1 watch.insn_retire
    |=> brk.a_after)
    else $error("after break missing");

  a_after_no_early: assert property (s_after_armed |=> !brk.a_before)
    else $error("after break fired early");

  a_data_filter: assert property (data_cmp_reg && watch.b_lbus &&
    !watch.b_lbus_data && !flag_q[2] |=> !flag_q[2])
    else $error("data compare ignored");

  a_ibus_filter: assert property (data_cmp_reg && watch.b_ibus &&
    !watch.b_ibus_data && !flag_q[0] |=> !flag_q[0])
    else $error("ibus data compare ignored");

  a_b_break_raw: assert property (watch.b_ibus && !data_cmp_reg
    |=> brk.b_break)
    else $error("channel B break missing");

endmodule : bcf_break_ctrl

/* bcf_core_model.sv */
// Core bus model: turns bench hit requests into watch pulses
`timescale 1ns/1ps
module bcf_core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Requests from the bench
  input wire bcf_pkg::bcf_watch_t req,
  input wire logic [3:0] retire_gap,
  // Watched core signals
  output bcf_pkg::bcf_watch_t watch
);
  logic [3:0] cnt;

  // Fetched instruction retires a few cycles after its fetch hit
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      watch <= '0;
      cnt <= 4'h0;
    end
    else
    begin
      watch <= {req[7:1], cnt == 4'h1};
      if (req.a_fetch)
        cnt <= retire_gap + 4'h1;
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
    end
  end
endmodule : bcf_core_model

/* break_control_flags_tb.sv */
// Testbench for the break control flags register
`timescale 1ns/1ps
module break_control_flags_tb;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, w;
  logic pready, pslverr, irq, trace_en, dcmp_en, ftim_a;
  bcf_pkg::bcf_watch_t req = '0, watch, r;
  bcf_pkg::bcf_break_t brk;
  logic [3:0] gap = 4'h1, fl = 4'h0, st = 4'h0, mk = 4'h0;
  logic tr = 1'h0, dc = 1'h0, tm = 1'h0;
  logic [2:0] k;
  int bad_count = 0, tests_run = 0, n_after = 0;
  int seed = 32'hD20CFE23;

  always #50 clk_sys = ~clk_sys;

  bcf_core_model u_core (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
    .retire_gap(gap), .watch(watch));
  bcf_break_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .watch(watch),
    .brk(brk), .pc_trace_enable(trace_en), .data_compare_enable_b(dcmp_en),
    .fetch_break_timing_a(ftim_a), .irq(irq));

  always @(posedge clk_sys)
    if (brk.a_after === 1'h1)
      n_after++;

  task automatic tally_and_finish;
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] reg_val(input logic [11:0] a);
    case (a)
      bcf_pkg::OFS_CTRL: reg_val = {16'h0, fl, tr, tm, 2'h0, dc, 7'h00};
      bcf_pkg::OFS_IRQ_STAT: reg_val = {28'h0, st};
      bcf_pkg::OFS_IRQ_MASK: reg_val = {28'h0, mk};
      default: reg_val = 32'h0;
    endcase
  endfunction : reg_val

  // One APB transfer carrying a bus hit request, then an idle cycle
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input bcf_pkg::bcf_watch_t q);
    logic [3:0] hit;
    logic [31:0] rd;
    logic tm_old;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    req <= q;
    @(posedge clk_sys);
    penable <= 1'h1;
    req <= '0;
    do @(posedge clk_sys); while (pready !== 1'h1);
    rd = prdata;
    check("pslverr", pslverr, a == 12'h00C);
    check("pready", pready, 32'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    hit = {q.a_lbus, q.b_lbus & (!dc | q.b_lbus_data), q.a_ibus,
      q.b_ibus & (!dc | q.b_ibus_data)};
    tm_old = tm;
    if (!wr)
      check("read data", rd, reg_val(a));
    else if (a == 12'h000)
    begin
      fl = fl & d[15:12];
      tr = d[11];
      tm = d[10];
      dc = d[7];
    end
    else if (a == 12'h004)
      st = st & ~d[3:0];
    else if (a == 12'h008)
      mk = d[3:0];
    fl = fl | hit;
    st = st | hit;
    @(negedge clk_sys);
    check("irq", irq, |(st & mk));
    check("b break", brk.b_break, hit[2] | hit[0]);
    check("a before", brk.a_before, q.a_fetch & !tm_old);
    check("controls", {trace_en, ftim_a, dcmp_en}, {tr, tm, dc});
    @(posedge clk_sys);
  endtask : apb

  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'h1;
    apb(1'h0, 12'h000, 32'h0, '0);
    apb(1'h1, 12'h000, 32'h0000_F880, '0);
    apb(1'h0, 12'h000, 32'h0, '0);
    apb(1'h1, 12'h008, 32'hF, '0);
    apb(1'h1, 12'h000, 32'h0, 8'hF0);
    apb(1'h0, 12'h000, 32'h0, '0);
    repeat (90)
    begin
      k = 3'($random(seed));
      w = $random(seed);
      r = 8'($random(seed)) & 8'hFE;
      apb(k[0], {8'h00, k[2:1], 2'h0},
        (k[2:1] == 2'h0) ? (w & 32'h0000_F880) : (w & 32'hF), r);
    end
    apb(1'h1, 12'h000, 32'h0000_0400, '0);
    for (int i = 0; i < 2; i++)
    begin
      gap <= (i == 0) ? 4'h3 : 4'h0;
      apb(1'h0, 12'h008, 32'h0, 8'h02);
      repeat (8) @(posedge clk_sys);
    end
    check("after breaks", n_after, 32'h2);
    tally_and_finish;
  end

  initial
  begin
    #(3000 * 100);
    bad_count++;
    tally_and_finish;
  end
endmodule : break_control_flags_tb
